// ===== sat_timer_defines.svh
// Named offsets, field positions, reset values and divide counts of the split auto-reload timer.
// Assumes it is included by bare name from every file that needs a number.
`ifndef SAT_TIMER_DEFINES_SVH
`define SAT_TIMER_DEFINES_SVH

// ==========================================================================
// Special-function register addresses
`define SAT_ADDR_CTRL      8'hc8
`define SAT_ADDR_RELOAD_L  8'hca
`define SAT_ADDR_RELOAD_H  8'hcb
`define SAT_ADDR_COUNT_L   8'hcc
`define SAT_ADDR_COUNT_H   8'hcd

// ==========================================================================
// Control register bit positions
`define SAT_CTRL_HFLAG     7
`define SAT_CTRL_LFLAG     6
`define SAT_CTRL_LIEN      5
`define SAT_CTRL_CEN       4
`define SAT_CTRL_SPLIT     3
`define SAT_CTRL_RUN       2
`define SAT_CTRL_UNUSED    1
`define SAT_CTRL_XCLK      0

// ==========================================================================
// Values
`define SAT_BYTE_RESET     8'h00
`define SAT_BYTE_ZERO      8'h00
`define SAT_BYTE_MAX       8'hff
`define SAT_BYTE_ONE       8'h01
`define SAT_READ_NONE      8'h00
`define SAT_SYS_DIV        12
`define SAT_EXT_DIV        8

`endif

// ===== sat_pkg.sv
// Types shared by the split auto-reload timer files.
// Assumes the defines header is available for numeric values.
package sat_pkg;

	// ==========================================================================
	// Operating mode
	typedef enum logic [0:0] {
		SAT_MODE_WIDE  = 1'b0,
		SAT_MODE_SPLIT = 1'b1
	} sat_mode_t;

	typedef logic [7:0] sat_byte_t;

endpackage : sat_pkg

// ===== sat_prescale.sv
// Tick sources for the timer: system clock divided by 12, external oscillator divided by 8,
// and falling edges of the low-frequency oscillator, all as one-cycle system-clock pulses.
// Assumes both oscillator inputs are slow against the system clock (under half its rate).
`timescale 1ns/100ps
`default_nettype none
`include "sat_timer_defines.svh"

module sat_prescale #(
	parameter int unsigned SYS_DIV = `SAT_SYS_DIV,
	parameter int unsigned EXT_DIV = `SAT_EXT_DIV
) (
	input  wire logic clock_i,
	input  wire logic rstn_i,
	input  wire logic ext_osc_i,
	input  wire logic lfo_i,
	output logic      div12_tick_o,
	output logic      ext8_tick_o,
	output logic      lfo_fall_o
);
	import sat_pkg::*;

	// ==========================================================================
	// System clock divider
	logic [3:0] sys_cnt_r;
	logic       sys_wrap;
	assign sys_wrap     = (sys_cnt_r == 4'(SYS_DIV - 1));
	assign div12_tick_o = sys_wrap;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sys_cnt_r <= 4'h0;
		end else begin
			sys_cnt_r <= sys_wrap ? 4'h0 : sys_cnt_r + 4'h1;
		end
	end

	// ==========================================================================
	// Oscillator synchronisers; the first stage feeds only the second.
	logic ext_meta_r, ext_sync_r, ext_prev_r;
	logic lfo_meta_r, lfo_sync_r, lfo_prev_r;
	logic [2:0] ext_cnt_r;
	logic ext_rise;
	logic ext_wrap;

	assign ext_rise    = ext_sync_r & ~ext_prev_r;
	assign ext_wrap    = ext_rise & (ext_cnt_r == 3'(EXT_DIV - 1));
	assign ext8_tick_o = ext_wrap;
	assign lfo_fall_o  = lfo_prev_r & ~lfo_sync_r;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
			lfo_meta_r <= 1'b0;
			lfo_sync_r <= 1'b0;
			lfo_prev_r <= 1'b0;
			ext_cnt_r  <= 3'h0;
		end else begin
			ext_meta_r <= ext_osc_i;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
			lfo_meta_r <= lfo_i;
			lfo_sync_r <= lfo_meta_r;
			lfo_prev_r <= lfo_sync_r;
			if (ext_rise) begin
				ext_cnt_r <= ext_wrap ? 3'h0 : ext_cnt_r + 3'h1;
			end
		end
	end

endmodule : sat_prescale
`default_nettype wire

// ===== sat_timer.sv
// Split auto-reload 16-bit timer with control, reload and count registers on the SFR port.
// Assumes a single-cycle SFR write strobe and a read strobe answered one cycle later.
`timescale 1ns/100ps
`default_nettype none
`include "sat_timer_defines.svh"

module sat_timer (
	input  wire logic               clock_i,
	input  wire logic               rstn_i,
	input  wire logic [7:0]         sfr_addr_i,
	input  wire logic               sfr_wr_i,
	input  wire logic               sfr_rd_i,
	input  wire sat_pkg::sat_byte_t sfr_wdata_i,
	output var  sat_pkg::sat_byte_t sfr_rdata_o,
	input  wire logic               high_byte_clock_select_i,
	input  wire logic               low_byte_clock_select_i,
	input  wire logic               timer_global_irq_enable_i,
	input  wire logic               ext_osc_i,
	input  wire logic               lfo_i,
	output var  logic               irq_o
);
	import sat_pkg::*;

	function automatic logic byte_at_max(input sat_byte_t b);
		byte_at_max = (b == `SAT_BYTE_MAX);
	endfunction : byte_at_max

	// ==========================================================================
	// Reset release
	logic rst_meta_r, rst_sync_r, rstn_s;
	assign rstn_s = rst_sync_r;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ==========================================================================
	// State
	logic      high_overflow_flag_r, low_overflow_flag_r, low_byte_irq_enable_r;
	logic      lfo_capture_enable_r, run_control_r, ext_clock_select_r;
	sat_mode_t split_mode_select_r;
	sat_byte_t reload_low_byte_r, reload_high_byte_r;
	sat_byte_t count_low_byte_r, count_high_byte_r;
	sat_byte_t rdata_r;
	logic      cap_pulse_r;

	// ==========================================================================
	// Tick sources
	logic div12_tick, ext8_tick, lfo_fall;

	sat_prescale u_prescale (
		.clock_i      (clock_i),
		.rstn_i       (rstn_s),
		.ext_osc_i    (ext_osc_i),
		.lfo_i        (lfo_i),
		.div12_tick_o (div12_tick),
		.ext8_tick_o  (ext8_tick),
		.lfo_fall_o   (lfo_fall)
	);

	// ==========================================================================
	// Decode
	logic wr_ctrl, wr_rl_l, wr_rl_h, wr_cnt_l, wr_cnt_h;
	assign wr_ctrl  = sfr_wr_i & (sfr_addr_i == `SAT_ADDR_CTRL);
	assign wr_rl_l  = sfr_wr_i & (sfr_addr_i == `SAT_ADDR_RELOAD_L);
	assign wr_rl_h  = sfr_wr_i & (sfr_addr_i == `SAT_ADDR_RELOAD_H);
	assign wr_cnt_l = sfr_wr_i & (sfr_addr_i == `SAT_ADDR_COUNT_L);
	assign wr_cnt_h = sfr_wr_i & (sfr_addr_i == `SAT_ADDR_COUNT_H);

	// ==========================================================================
	// Counting
	logic is_split, divided_tick, low_tick, high_tick;
	logic low_inc, high_inc, low_ovf, high_ovf, cap_evt;

	assign is_split     = (split_mode_select_r == SAT_MODE_SPLIT);
	assign divided_tick = ext_clock_select_r ? ext8_tick : div12_tick;
	assign low_tick     = low_byte_clock_select_i | divided_tick;
	assign high_tick    = high_byte_clock_select_i | divided_tick;
	assign low_inc      = is_split ? low_tick : (run_control_r & low_tick);
	assign high_inc     = is_split ? (run_control_r & high_tick)
	                               : (low_inc & byte_at_max(count_low_byte_r));
	assign low_ovf      = low_inc & byte_at_max(count_low_byte_r);
	assign high_ovf     = high_inc & byte_at_max(count_high_byte_r);
	assign cap_evt      = lfo_capture_enable_r & timer_global_irq_enable_i & lfo_fall;

	// A software write to a count byte wins over the increment of that same cycle.
	sat_byte_t cnt_l_nxt, cnt_h_nxt, rl_l_nxt, rl_h_nxt, ctrl_rd;
	assign cnt_l_nxt = wr_cnt_l ? sfr_wdata_i :
	                   (low_ovf & (is_split | high_ovf)) ? reload_low_byte_r :
	                   low_ovf ? `SAT_BYTE_ZERO :
	                   low_inc ? count_low_byte_r + `SAT_BYTE_ONE : count_low_byte_r;
	assign cnt_h_nxt = wr_cnt_h ? sfr_wdata_i :
	                   high_ovf ? reload_high_byte_r :
	                   high_inc ? count_high_byte_r + `SAT_BYTE_ONE : count_high_byte_r;
	// Capture takes priority over a software reload write in the same cycle.
	assign rl_l_nxt  = cap_evt ? count_low_byte_r : (wr_rl_l ? sfr_wdata_i : reload_low_byte_r);
	assign rl_h_nxt  = cap_evt ? count_high_byte_r : (wr_rl_h ? sfr_wdata_i : reload_high_byte_r);

	logic hflag_nxt, lflag_nxt;
	// Hardware set wins over a software clear in the same cycle.
	assign hflag_nxt = high_ovf | (wr_ctrl ? sfr_wdata_i[`SAT_CTRL_HFLAG] : high_overflow_flag_r);
	assign lflag_nxt = low_ovf | (wr_ctrl ? sfr_wdata_i[`SAT_CTRL_LFLAG] : low_overflow_flag_r);

	// ==========================================================================
	// Read mux
	assign ctrl_rd = {high_overflow_flag_r, low_overflow_flag_r, low_byte_irq_enable_r,
	                  lfo_capture_enable_r, split_mode_select_r, run_control_r, 1'b0, ext_clock_select_r};
	sat_byte_t rd_sel;
	assign rd_sel = (sfr_addr_i == `SAT_ADDR_CTRL)     ? ctrl_rd :
	                (sfr_addr_i == `SAT_ADDR_RELOAD_L) ? reload_low_byte_r :
	                (sfr_addr_i == `SAT_ADDR_RELOAD_H) ? reload_high_byte_r :
	                (sfr_addr_i == `SAT_ADDR_COUNT_L)  ? count_low_byte_r :
	                (sfr_addr_i == `SAT_ADDR_COUNT_H)  ? count_high_byte_r : `SAT_READ_NONE;
	assign sfr_rdata_o = rdata_r;

	// ==========================================================================
	// Interrupt request: flags stay set, so a flag request stays pending until software clears; a capture request lasts one cycle.
	assign irq_o = timer_global_irq_enable_i &
	               (high_overflow_flag_r | (low_byte_irq_enable_r & low_overflow_flag_r) | cap_pulse_r);

	// ==========================================================================
	// Registers
	always_ff @(posedge clock_i or negedge rstn_s) begin
		if (!rstn_s) begin
			high_overflow_flag_r  <= 1'b0;
			low_overflow_flag_r   <= 1'b0;
			low_byte_irq_enable_r <= 1'b0;
			lfo_capture_enable_r  <= 1'b0;
			split_mode_select_r   <= SAT_MODE_WIDE;
			run_control_r         <= 1'b0;
			ext_clock_select_r    <= 1'b0;
			reload_low_byte_r     <= `SAT_BYTE_RESET;
			reload_high_byte_r    <= `SAT_BYTE_RESET;
			count_low_byte_r      <= `SAT_BYTE_RESET;
			count_high_byte_r     <= `SAT_BYTE_RESET;
			rdata_r               <= `SAT_BYTE_RESET;
			cap_pulse_r           <= 1'b0;
		end else begin
			high_overflow_flag_r <= hflag_nxt;
			low_overflow_flag_r  <= lflag_nxt;
			if (wr_ctrl) begin
				low_byte_irq_enable_r <= sfr_wdata_i[`SAT_CTRL_LIEN];
				lfo_capture_enable_r  <= sfr_wdata_i[`SAT_CTRL_CEN];
				split_mode_select_r   <= sat_mode_t'(sfr_wdata_i[`SAT_CTRL_SPLIT]);
				run_control_r         <= sfr_wdata_i[`SAT_CTRL_RUN];
				ext_clock_select_r    <= sfr_wdata_i[`SAT_CTRL_XCLK];
			end
			reload_low_byte_r  <= rl_l_nxt;
			reload_high_byte_r <= rl_h_nxt;
			count_low_byte_r   <= cnt_l_nxt;
			count_high_byte_r  <= cnt_h_nxt;
			rdata_r            <= sfr_rd_i ? rd_sel : rdata_r;
			cap_pulse_r        <= cap_evt;
		end
	end

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_s);

	property p_low_flag;
		low_ovf |=> low_overflow_flag_r;
	endproperty
	a_low_flag: assert property (p_low_flag) else $error("low flag not set on low rollover");

	property p_high_flag;
		high_ovf |=> high_overflow_flag_r;
	endproperty
	a_high_flag: assert property (p_high_flag) else $error("high flag not set on high rollover");

	property p_wide_reload;
		!is_split && high_ovf && !wr_cnt_l && !wr_cnt_h |=>
			{count_high_byte_r, count_low_byte_r} == $past({reload_high_byte_r, reload_low_byte_r});
	endproperty
	a_wide_reload: assert property (p_wide_reload) else $error("wide overflow did not reload");

	property p_split_low_runs;
		is_split && !run_control_r && low_byte_clock_select_i && !wr_cnt_l && !low_ovf |=>
			count_low_byte_r == $past(count_low_byte_r) + `SAT_BYTE_ONE;
	endproperty
	a_split_low_runs: assert property (p_split_low_runs) else $error("split low byte did not count");

	property p_split_high_hold;
		is_split && !run_control_r && !wr_cnt_h |=> $stable(count_high_byte_r);
	endproperty
	a_split_high_hold: assert property (p_split_high_hold) else $error("split high byte moved while stopped");

	property p_wide_hold;
		!is_split && !run_control_r && !wr_cnt_l && !wr_cnt_h |=>
			$stable(count_low_byte_r) && $stable(count_high_byte_r);
	endproperty
	a_wide_hold: assert property (p_wide_hold) else $error("wide counter moved while stopped");

	property p_irq_pending;
		timer_global_irq_enable_i && high_overflow_flag_r |-> irq_o;
	endproperty
	a_irq_pending: assert property (p_irq_pending) else $error("set flag without request");

	property p_low_irq_masked;
		!low_byte_irq_enable_r && !high_overflow_flag_r && !cap_pulse_r |-> !irq_o;
	endproperty
	a_low_irq_masked: assert property (p_low_irq_masked) else $error("request without cause");

	property p_capture;
		cap_evt |=> {reload_high_byte_r, reload_low_byte_r} == $past({count_high_byte_r, count_low_byte_r})
			##0 irq_o;
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy count");

	property p_bit1_zero;
		sfr_rd_i && sfr_addr_i == `SAT_ADDR_CTRL |=> sfr_rdata_o[`SAT_CTRL_UNUSED] == 1'b0;
	endproperty
	a_bit1_zero: assert property (p_bit1_zero) else $error("unused control bit read as one");

	property p_flag_sticky;
		high_overflow_flag_r && !wr_ctrl |=> high_overflow_flag_r [*1];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

	property p_div12_gap;
		div12_tick |=> !div12_tick [*8];
	endproperty
	a_div12_gap: assert property (p_div12_gap) else $error("divided tick too frequent");

	property p_wide_irq;
		!is_split && high_ovf |=> high_overflow_flag_r && (irq_o || !timer_global_irq_enable_i);
	endproperty
	a_wide_irq: assert property (p_wide_irq) else $error("full overflow without request");

	property p_wide_low_irq;
		!is_split && low_ovf && low_byte_irq_enable_r && !wr_ctrl |=>
			irq_o || !timer_global_irq_enable_i;
	endproperty
	a_wide_low_irq: assert property (p_wide_low_irq) else $error("low rollover without request");

	property p_split_irq;
		is_split && (high_ovf || (low_ovf && low_byte_irq_enable_r)) && !wr_ctrl |=>
			irq_o || !timer_global_irq_enable_i;
	endproperty
	a_split_irq: assert property (p_split_irq) else $error("split overflow without request");

	property p_split_reload_low;
		is_split && low_ovf && !wr_cnt_l |=> count_low_byte_r == $past(reload_low_byte_r);
	endproperty
	a_split_reload_low: assert property (p_split_reload_low) else $error("low byte did not reload");

	property p_split_reload_high;
		is_split && high_ovf && !wr_cnt_h |=> count_high_byte_r == $past(reload_high_byte_r);
	endproperty
	a_split_reload_high: assert property (p_split_reload_high) else $error("high byte did not reload");

	property p_wide_step;
		!is_split && low_inc && !low_ovf && !wr_cnt_l && !wr_cnt_h |=>
			count_low_byte_r == $past(count_low_byte_r) + `SAT_BYTE_ONE && $stable(count_high_byte_r);
	endproperty
	a_wide_step: assert property (p_wide_step) else $error("wide counter did not step by one");

	property p_wide_sys_select;
		!is_split && run_control_r && low_byte_clock_select_i |-> low_inc;
	endproperty
	a_wide_sys_select: assert property (p_wide_sys_select) else $error("wide timer missed a clock");

	property p_split_high_sys;
		is_split && run_control_r && high_byte_clock_select_i |-> high_inc;
	endproperty
	a_split_high_sys: assert property (p_split_high_sys) else $error("split high byte missed a clock");

	property p_lfo_single;
		lfo_fall |=> !lfo_fall;
	endproperty
	a_lfo_single: assert property (p_lfo_single) else $error("falling edge gave two events");

	property p_ext_gap;
		ext8_tick |=> !ext8_tick [*8];
	endproperty
	a_ext_gap: assert property (p_ext_gap) else $error("external tick too frequent");

	property p_lflag_sticky;
		low_overflow_flag_r && !wr_ctrl |=> low_overflow_flag_r;
	endproperty
	a_lflag_sticky: assert property (p_lflag_sticky) else $error("low flag cleared by hardware");

	c_wide_ovf:  cover property (!is_split && high_ovf);
	c_split_low: cover property (is_split && low_ovf);
	c_split_hi:  cover property (is_split && high_ovf);
	c_capture:   cover property (cap_evt);
	c_low_irq:   cover property (irq_o && low_byte_irq_enable_r && low_overflow_flag_r);

endmodule : sat_timer
`default_nettype wire

// ===== sat_timer_tb.sv
// Self-checking bench for the split auto-reload timer: registers, counting, flags and capture.
// Assumes the timer carries its own assertions; the bench drives every input itself.
`timescale 1ns/100ps
`default_nettype none
`include "sat_timer_defines.svh"

module sat_timer_tb;
	import sat_pkg::*;
	logic        clock_i     = 1'b0;
	logic        rstn_i      = 1'b0;
	logic [7:0]  sfr_addr_i  = 8'h00;
	logic        sfr_wr_i    = 1'b0;
	logic        sfr_rd_i    = 1'b0;
	sat_byte_t   sfr_wdata_i = 8'h00;
	sat_byte_t   sfr_rdata_o;
	logic        hsel        = 1'b1;
	logic        lsel        = 1'b1;
	logic        gie         = 1'b1;
	logic        ext_osc     = 1'b0;
	logic        lfo         = 1'b1;
	logic        irq_o;
	logic [1:0]  ext_cnt     = 2'h0;
	logic [31:0] seed        = 32'h4510af39;
	logic [7:0]  v;
	logic [7:0]  ra;
	logic [7:0]  rb;
	int          mismatches  = 0;
	int          num_checks  = 0;
	int          pulses;

	sat_timer dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
		.sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
		.high_byte_clock_select_i(hsel), .low_byte_clock_select_i(lsel),
		.timer_global_irq_enable_i(gie), .ext_osc_i(ext_osc), .lfo_i(lfo), .irq_o(irq_o));

	always #2.5 clock_i = ~clock_i;

	// The external oscillator runs at a quarter of the system clock, well under the half-rate limit.
	always @(posedge clock_i) begin
		ext_cnt <= ext_cnt + 2'h1;
		ext_osc <= ext_cnt[1];
	end

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [7:0] in_range(input logic [7:0] seen, input int lo, input int hi);
		return (int'(seen) >= lo && int'(seen) <= hi) ? 8'h01 : 8'h00;
	endfunction : in_range

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		sfr_addr_i  <= a;
		sfr_wdata_i <= d;
		sfr_wr_i    <= 1'b1;
		@(posedge clock_i);
		sfr_wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		sfr_addr_i <= a;
		sfr_rd_i   <= 1'b1;
		@(posedge clock_i);
		sfr_rd_i   <= 1'b0;
		@(posedge clock_i);
		d = sfr_rdata_o;
	endtask : rd

	task automatic wait_irq(input int limit);
		int i;
		for (i = 0; i < limit && irq_o !== 1'b1; i++) begin
			@(posedge clock_i);
		end
		if (irq_o !== 1'b1) begin
			mismatches++;
			$display("wrong value irq_o expected 01 seen 00");
			report_and_stop();
		end
	endtask : wait_irq

	task automatic load(input logic [7:0] ctl, input logic [7:0] cl, input logic [7:0] ch);
		wr(`SAT_ADDR_CTRL, 8'h00);
		wr(`SAT_ADDR_COUNT_L, cl);
		wr(`SAT_ADDR_COUNT_H, ch);
		wr(`SAT_ADDR_CTRL, ctl);
	endtask : load

	// ==========================================================================
	// Scenarios
	initial begin
		int k;
		int n;
		logic [7:0] adrs [6] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
		cyc(10);
		rstn_i <= 1'b1;
		cyc(3);
		for (k = 0; k < 6; k++) begin
			rd(adrs[k], v);
			check("reset value", v, `SAT_BYTE_RESET);
		end
		for (k = 1; k < 6; k++) begin
			seed = xs(seed);
			wr(adrs[k], seed[7:0]);
			rd(adrs[k], v);
			check("register readback", v, (k == 5) ? `SAT_READ_NONE : seed[7:0]);
		end
		wr(`SAT_ADDR_CTRL, 8'h02);
		rd(`SAT_ADDR_CTRL, v);
		check("timer_control", v, 8'h00);
		// Rate per clock source: system clock, divide by 12, external divide by 8.
		for (k = 0; k < 3; k++) begin
			lsel <= (k == 0);
			n = (k == 0) ? 40 : (k == 1) ? 120 : 256;
			load(8'h04 | ((k == 2) ? 8'h01 : 8'h00), 8'h00, 8'h00);
			cyc(n);
			wr(`SAT_ADDR_CTRL, 8'h00);
			rd(`SAT_ADDR_COUNT_L, ra);
			n = n / ((k == 0) ? 1 : (k == 1) ? `SAT_SYS_DIV : 4 * `SAT_EXT_DIV);
			check("tick count", in_range(ra, n - 1, n + 3), 8'h01);
			cyc(20);
			rd(`SAT_ADDR_COUNT_L, rb);
			check("stopped count", rb, ra);
		end
		// Full 16-bit overflow reloads the pair and raises a request that stays pending.
		lsel <= 1'b1;
		seed = xs(seed);
		rb = {1'b0, seed[14:8]};
		wr(`SAT_ADDR_RELOAD_L, 8'h00);
		wr(`SAT_ADDR_RELOAD_H, rb);
		load(8'h04, 8'hf0, 8'hff);
		wait_irq(40);
		rd(`SAT_ADDR_CTRL, v);
		check("timer_control", v, 8'hc4);
		rd(`SAT_ADDR_COUNT_H, v);
		check("count_high_byte", v, rb);
		cyc(20);
		check("irq_o", {7'h0, irq_o}, 8'h01);
		gie <= 1'b0;
		cyc(1);
		check("irq_o", {7'h0, irq_o}, 8'h00);
		gie <= 1'b1;
		// Low byte rollover in wide mode: flag always, request only with the low enable.
		load(8'h04, 8'hf8, 8'h00);
		cyc(30);
		check("irq_o", {7'h0, irq_o}, 8'h00);
		rd(`SAT_ADDR_CTRL, v);
		check("timer_control", v, 8'h44);
		rd(`SAT_ADDR_COUNT_H, v);
		check("count_high_byte", v, 8'h01);
		wr(`SAT_ADDR_CTRL, 8'h64);
		cyc(1);
		check("irq_o", {7'h0, irq_o}, 8'h01);
		// Split mode: own reloads, low byte free running, high byte held by run control.
		seed = xs(seed);
		ra = {1'b0, seed[6:0]};
		rb = {1'b0, seed[14:8]};
		wr(`SAT_ADDR_RELOAD_L, ra);
		wr(`SAT_ADDR_RELOAD_H, rb);
		load(8'h08, 8'hf0, 8'h55);
		cyc(40);
		rd(`SAT_ADDR_COUNT_H, v);
		check("count_high_byte", v, 8'h55);
		rd(`SAT_ADDR_CTRL, v);
		check("timer_control", v, 8'h48);
		check("irq_o", {7'h0, irq_o}, 8'h00);
		rd(`SAT_ADDR_COUNT_L, v);
		check("count_low_byte", in_range(v, ra + 25, ra + 40), 8'h01);
		hsel <= 1'b0;
		load(8'h0c, 8'h00, 8'hfe);
		wait_irq(60);
		rd(`SAT_ADDR_CTRL, v);
		check("timer_control", v & 8'hbf, 8'h8c);
		rd(`SAT_ADDR_COUNT_H, v);
		check("count_high_byte", in_range(v, rb, rb + 1), 8'h01);
		load(8'h28, 8'h00, 8'h00);
		wait_irq(300);
		// Capture on the falling oscillator edge only, one request per edge.
		hsel <= 1'b1;
		for (k = 0; k < 2; k++) begin
			load(8'h14, 8'h00, 8'h00);
			cyc(10);
			lfo <= (k == 1);
			pulses = 0;
			repeat (20) begin
				@(posedge clock_i);
				pulses += (irq_o === 1'b1);
			end
			check("capture requests", 8'(pulses), (k == 0) ? 8'h01 : 8'h00);
		end
		rd(`SAT_ADDR_RELOAD_H, v);
		check("reload_high_byte", v, 8'h00);
		rd(`SAT_ADDR_RELOAD_L, v);
		check("reload_low_byte", in_range(v, 8, 40), 8'h01);
		report_and_stop();
	end
endmodule : sat_timer_tb
`default_nettype wire
